// ===== include/clkctl_defines.svh
/*
 * Constants of the clock output control bank: byte offsets, reset values,
 * field positions and the index of each gated output.
 * Assumes inclusion by bare name from the include directory.
 */
`ifndef CLKCTL_DEFINES_SVH
`define CLKCTL_DEFINES_SVH

// Byte offsets
`define OFS_OUTPUT_ENABLE_A 7'h02
`define OFS_OUTPUT_ENABLE_B 7'h03
`define OFS_SERIAL_REF_STOP_SELECT 7'h04
`define OFS_STOP_AND_POWERDOWN_SELECT 7'h05
`define OFS_STOP_DRIVE_MODE 7'h06
`define OFS_TEST_AND_SENSE 7'h07

// Reset values
`define RST_OUTPUT_ENABLE_A 8'hFF
`define RST_OUTPUT_ENABLE_B 8'hFF
`define RST_SERIAL_REF_STOP_SELECT 8'h00
`define RST_STOP_AND_POWERDOWN_SELECT 8'h07
`define RST_STOP_DRIVE_MODE 8'h00
`define RST_TEST_AND_SENSE 8'h00
`define RST_RDATA 8'h00

// Writable bits of the test byte
`define MASK_TEST_AND_SENSE 8'hC0

// Field positions
`define POS_SPREAD_ENABLE 0
`define POS_FREE_PCI_CLK0_ENABLE 7
`define POS_VIDEO_NONSPREAD_DOT_ENABLE 6
`define POS_USB_CLOCK_ENABLE 5
`define POS_REFERENCE_OUT0_ENABLE 4
`define POS_REFERENCE_OUT1_ENABLE 3
`define POS_PROC_PAIR1_ENABLE 2
`define POS_PROC_PAIR0_ENABLE 1
`define POS_PROC_PAIR2_SHARED_ENABLE 1
`define POS_BUS_CLOCK1_ENABLE 4
`define POS_FREE_PCI_CLK0_STOP_SELECT 3
`define POS_DOT_CLOCK_POWERDOWN_DRIVE 6
`define POS_PANEL_CLOCK_POWERDOWN_DRIVE 7
`define POS_SERIAL_REF_STOP_DRIVE 7
`define POS_PROC_PAIR0_STOP_DRIVE 4
`define POS_SERIAL_REF_POWERDOWN_DRIVE 3
`define POS_PROC_PAIR0_POWERDOWN_DRIVE 0
`define POS_TEST_SELECT 7
`define POS_TEST_ENTRY 6

// Gated output indices
`define IDX_PROC 0
`define IDX_SERIAL 3
`define IDX_FREE_PCI0 11
`define IDX_BUS 12
`define IDX_USB 16
`define IDX_REF0 17
`define IDX_REF1 18
`define IDX_VIDEO 19
`define IDX_PANEL 20
`define NUM_OUT 21

`endif

// ===== include/clkctl_pkg.sv
/*
 * Types shared by the clock output control bank.
 * Assumes the byte register port of an external bus protocol engine.
 */
package clkctl_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic run;
        logic drive;
    } gate_state_t;

endpackage

// ===== src/clk_gate_cell.sv
/*
 * One output gate: takes the wanted run and drive state only while the
 * output clock is low, so the output never shows a shortened pulse.
 * Assumes at_low is synchronous to clk and marks a low phase of the output.
 */
`timescale 1ns/100ps
module clk_gate_cell (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic at_low,
    input wire clkctl_pkg::gate_state_t want,
    output clkctl_pkg::gate_state_t state_q
);
    clkctl_pkg::gate_state_t state_d;

    // Hold until a low phase
    assign state_d = at_low ? want : state_q;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= '{run: 1'b0, drive: 1'b1};
        end
        else
        begin
            state_q <= state_d;
        end
    end
endmodule

// ===== src/clk_output_control.sv
/*
 * Control bank of a multi-output clock generator: bytes 2 to 6 and the
 * test bits of byte 7, the enables, stop selects and drive modes built
 * from them, and one glitch-free gate per output.
 * Assumes a protocol engine presents single byte accesses on REG_REQ,
 * stepping the offset itself during block transfers, and that stop and
 * power-down inputs and CLK_LOW are synchronous to CLK.
 */
`timescale 1ns/100ps
`include "clkctl_defines.svh"
module clk_output_control (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire clkctl_pkg::reg_req_t REG_REQ,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    input wire logic BUS_CLOCK_STOP_N,
    input wire logic PROC_CLOCK_STOP_N,
    input wire logic POWER_DOWN,
    input wire logic SW_BUS_STOP,
    input wire logic [`NUM_OUT-1:0] CLK_LOW,
    output logic [`NUM_OUT-1:0] OUT_RUN,
    output logic [`NUM_OUT-1:0] OUT_DRIVE,
    output logic SPREAD_ON,
    output logic TEST_REF_DIV
);
    logic [7:0] enable_a_q;
    logic [7:0] enable_b_q;
    logic [7:0] stop_sel_q;
    logic [7:0] stop_pd_q;
    logic [7:0] drive_mode_q;
    logic [7:0] test_q;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic hit_a;
    logic hit_b;
    logic hit_stop;
    logic hit_stop_pd;
    logic hit_drive;
    logic hit_test;
    logic bus_stop;
    logic proc_stop;
    logic test_entry;
    logic test_tristate;
    logic [2:0] proc_en;
    logic [2:0] proc_stopped;
    logic [7:0] serial_stopped;
    logic [7:0] serial_pd_tri;
    logic [3:0] bus_en;
    logic [`NUM_OUT-1:0] want_run;
    logic [`NUM_OUT-1:0] want_drive;

    // Address decode
    assign hit_a = REG_REQ.addr == `OFS_OUTPUT_ENABLE_A;
    assign hit_b = REG_REQ.addr == `OFS_OUTPUT_ENABLE_B;
    assign hit_stop = REG_REQ.addr == `OFS_SERIAL_REF_STOP_SELECT;
    assign hit_stop_pd = REG_REQ.addr == `OFS_STOP_AND_POWERDOWN_SELECT;
    assign hit_drive = REG_REQ.addr == `OFS_STOP_DRIVE_MODE;
    assign hit_test = REG_REQ.addr == `OFS_TEST_AND_SENSE;

    // Read selection, unmapped offsets read zero
    assign rdata_d = hit_a ? enable_a_q :
                     hit_b ? enable_b_q :
                     hit_stop ? stop_sel_q :
                     hit_stop_pd ? stop_pd_q :
                     hit_drive ? drive_mode_q :
                     hit_test ? test_q : `RST_RDATA;

    // Register bank
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            enable_a_q <= `RST_OUTPUT_ENABLE_A;
            enable_b_q <= `RST_OUTPUT_ENABLE_B;
            stop_sel_q <= `RST_SERIAL_REF_STOP_SELECT;
            stop_pd_q <= `RST_STOP_AND_POWERDOWN_SELECT;
            drive_mode_q <= `RST_STOP_DRIVE_MODE;
            test_q <= `RST_TEST_AND_SENSE;
        end
        else if (REG_REQ.wr)
        begin
            if (hit_a)
            begin
                enable_a_q <= REG_REQ.wdata;
            end
            if (hit_b)
            begin
                enable_b_q <= REG_REQ.wdata;
            end
            if (hit_stop)
            begin
                stop_sel_q <= REG_REQ.wdata;
            end
            if (hit_stop_pd)
            begin
                stop_pd_q <= REG_REQ.wdata;
            end
            if (hit_drive)
            begin
                drive_mode_q <= REG_REQ.wdata;
            end
            if (hit_test)
            begin
                test_q <= REG_REQ.wdata & `MASK_TEST_AND_SENSE;
            end
        end
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rdata_q <= `RST_RDATA;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rdata_q <= REG_REQ.rd ? rdata_d : rdata_q;
            rvalid_q <= REG_REQ.rd;
        end
    end

    assign REG_RDATA = rdata_q;
    assign REG_RVALID = rvalid_q;
    assign SPREAD_ON = enable_a_q[`POS_SPREAD_ENABLE];

    // Stop and test conditions
    assign bus_stop = !BUS_CLOCK_STOP_N || SW_BUS_STOP;
    assign proc_stop = !PROC_CLOCK_STOP_N;
    assign test_entry = test_q[`POS_TEST_ENTRY];
    assign test_tristate = test_entry && !test_q[`POS_TEST_SELECT];
    assign TEST_REF_DIV = test_entry && test_q[`POS_TEST_SELECT];

    // Processor pairs
    assign proc_en = {enable_b_q[`POS_PROC_PAIR2_SHARED_ENABLE],
                      enable_a_q[`POS_PROC_PAIR1_ENABLE],
                      enable_a_q[`POS_PROC_PAIR0_ENABLE]};
    assign proc_stopped = {3{proc_stop}} & stop_pd_q[2:0];
    assign want_run[`IDX_PROC+:3] = proc_en & ~proc_stopped & {3{!POWER_DOWN}};
    assign want_drive[`IDX_PROC+:3] =
        ~(proc_stopped & drive_mode_q[`POS_PROC_PAIR0_STOP_DRIVE+:3])
        & ~({3{POWER_DOWN}} & drive_mode_q[`POS_PROC_PAIR0_POWERDOWN_DRIVE+:3])
        & {3{!test_tristate}};

    // Serial references
    assign serial_stopped = {8{bus_stop}} & stop_sel_q;
    assign serial_pd_tri = {{7{POWER_DOWN && drive_mode_q[`POS_SERIAL_REF_POWERDOWN_DRIVE]}},
                            1'b0};
    assign want_run[`IDX_SERIAL+:8] = ~serial_stopped & {8{!POWER_DOWN}};
    assign want_drive[`IDX_SERIAL+:8] =
        ~(serial_stopped & {8{drive_mode_q[`POS_SERIAL_REF_STOP_DRIVE]}})
        & ~serial_pd_tri & {8{!test_tristate}};

    // Bus clocks and free-running bus clock
    assign bus_en = enable_b_q[`POS_BUS_CLOCK1_ENABLE+:4];
    assign want_run[`IDX_BUS+:4] = bus_en & {4{!bus_stop && !POWER_DOWN}};
    assign want_drive[`IDX_BUS+:4] = {4{!test_tristate}};
    assign want_run[`IDX_FREE_PCI0] = enable_a_q[`POS_FREE_PCI_CLK0_ENABLE]
        && !(bus_stop && stop_pd_q[`POS_FREE_PCI_CLK0_STOP_SELECT]) && !POWER_DOWN;
    assign want_drive[`IDX_FREE_PCI0] = !test_tristate;

    // Fixed-frequency outputs
    assign want_run[`IDX_USB] = enable_a_q[`POS_USB_CLOCK_ENABLE] && !POWER_DOWN;
    assign want_run[`IDX_REF0] = enable_a_q[`POS_REFERENCE_OUT0_ENABLE] && !POWER_DOWN;
    assign want_run[`IDX_REF1] = enable_a_q[`POS_REFERENCE_OUT1_ENABLE] && !POWER_DOWN;
    assign want_run[`IDX_VIDEO] = enable_a_q[`POS_VIDEO_NONSPREAD_DOT_ENABLE]
        && !POWER_DOWN;
    assign want_run[`IDX_PANEL] = !POWER_DOWN;
    assign want_drive[`IDX_USB] = !test_tristate;
    assign want_drive[`IDX_REF0] = !test_tristate;
    assign want_drive[`IDX_REF1] = !test_tristate;
    assign want_drive[`IDX_VIDEO] = !test_tristate
        && !(POWER_DOWN && stop_pd_q[`POS_DOT_CLOCK_POWERDOWN_DRIVE]);
    assign want_drive[`IDX_PANEL] = !test_tristate
        && !(POWER_DOWN && stop_pd_q[`POS_PANEL_CLOCK_POWERDOWN_DRIVE]);

    // One gate per output
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_OUT; gi++)
        begin : g_gate
            clkctl_pkg::gate_state_t cell_q;
            clk_gate_cell u_cell (
                .clk(CLK),
                .reset_n(RESET_N),
                .at_low(CLK_LOW[gi]),
                .want('{run: want_run[gi], drive: want_drive[gi]}),
                .state_q(cell_q)
            );
            assign OUT_RUN[gi] = cell_q.run;
            assign OUT_DRIVE[gi] = cell_q.drive;
        end
    endgenerate

    // Helper: first cycle after reset release
    logic first_q;
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            first_q <= 1'b1;
        end
        else
        begin
            first_q <= 1'b0;
        end
    end

    property p_enable_a_write;
        @(posedge CLK) disable iff (!RESET_N)
        REG_REQ.wr && hit_a |=> enable_a_q == $past(REG_REQ.wdata);
    endproperty
    a_enable_a_write: assert property (p_enable_a_write)
        else $error("Output enable byte A did not take the written value");

    property p_spread_follows;
        @(posedge CLK) disable iff (!RESET_N)
        REG_REQ.wr && hit_a |=> SPREAD_ON == $past(REG_REQ.wdata[`POS_SPREAD_ENABLE]);
    endproperty
    a_spread_follows: assert property (p_spread_follows)
        else $error("Spread control did not follow byte A bit 0");

    property p_bus_enable;
        @(posedge CLK) disable iff (!RESET_N)
        !bus_en[0] && CLK_LOW[`IDX_BUS] |=> !OUT_RUN[`IDX_BUS];
    endproperty
    a_bus_enable: assert property (p_bus_enable)
        else $error("Disabled bus clock 1 still runs");

    property p_reserved_reset;
        @(posedge CLK) disable iff (!RESET_N)
        first_q |-> enable_b_q[3:2] == 2'b11 && enable_b_q[0];
    endproperty
    a_reserved_reset: assert property (p_reserved_reset)
        else $error("Reserved bits of byte B not one after reset");

    property p_serial_stop;
        @(posedge CLK) disable iff (!RESET_N)
        bus_stop |-> (want_run[`IDX_SERIAL+:8] & stop_sel_q) == 8'h00;
    endproperty
    a_serial_stop: assert property (p_serial_stop)
        else $error("Selected serial reference runs during bus stop");

    property p_proc_stop;
        @(posedge CLK) disable iff (!RESET_N)
        proc_stop |-> (want_run[`IDX_PROC+:3] & stop_pd_q[2:0]) == 3'h0;
    endproperty
    a_proc_stop: assert property (p_proc_stop)
        else $error("Selected processor pair runs during processor stop");

    property p_proc_stop_drive;
        @(posedge CLK) disable iff (!RESET_N)
        proc_stop && stop_pd_q[0] && drive_mode_q[`POS_PROC_PAIR0_STOP_DRIVE]
            |-> !want_drive[`IDX_PROC];
    endproperty
    a_proc_stop_drive: assert property (p_proc_stop_drive)
        else $error("Stopped processor pair 0 still driven in tri-state mode");

    property p_test_gate;
        @(posedge CLK) disable iff (!RESET_N)
        !test_entry |-> !TEST_REF_DIV && !test_tristate;
    endproperty
    a_test_gate: assert property (p_test_gate)
        else $error("Test behaviour active without test entry");

    property p_glitch_free;
        @(posedge CLK) disable iff (!RESET_N)
        $changed(OUT_RUN[`IDX_REF0]) |-> $past(CLK_LOW[`IDX_REF0]);
    endproperty
    a_glitch_free: assert property (p_glitch_free)
        else $error("Reference output gate changed outside a low phase");

    property p_readback;
        @(posedge CLK) disable iff (!RESET_N)
        REG_REQ.rd && hit_drive && !REG_REQ.wr |=> REG_RVALID && REG_RDATA == $past(drive_mode_q);
    endproperty
    a_readback: assert property (p_readback)
        else $error("Drive mode byte read back wrong");

    property p_serial0_stop;
        @(posedge CLK) disable iff (!RESET_N)
        bus_stop && stop_sel_q[0] && CLK_LOW[`IDX_SERIAL] |=> !OUT_RUN[`IDX_SERIAL];
    endproperty
    a_serial0_stop: assert property (p_serial0_stop)
        else $error("Selected serial reference 0 runs during bus stop");

    property p_free_stop;
        @(posedge CLK) disable iff (!RESET_N)
        bus_stop && stop_pd_q[`POS_FREE_PCI_CLK0_STOP_SELECT] && CLK_LOW[`IDX_FREE_PCI0]
            |=> !OUT_RUN[`IDX_FREE_PCI0];
    endproperty
    a_free_stop: assert property (p_free_stop)
        else $error("Selected free bus clock 0 runs during bus stop");

    property p_panel_pd_drive;
        @(posedge CLK) disable iff (!RESET_N)
        POWER_DOWN && stop_pd_q[`POS_PANEL_CLOCK_POWERDOWN_DRIVE] && CLK_LOW[`IDX_PANEL]
            |=> !OUT_DRIVE[`IDX_PANEL];
    endproperty
    a_panel_pd_drive: assert property (p_panel_pd_drive)
        else $error("Panel clock driven in power-down tri-state mode");

    property p_dot_pd_drive;
        @(posedge CLK) disable iff (!RESET_N)
        POWER_DOWN && stop_pd_q[`POS_DOT_CLOCK_POWERDOWN_DRIVE] && CLK_LOW[`IDX_VIDEO]
            |=> !OUT_DRIVE[`IDX_VIDEO];
    endproperty
    a_dot_pd_drive: assert property (p_dot_pd_drive)
        else $error("Dot clock driven in power-down tri-state mode");

    property p_serial_stop_drive;
        @(posedge CLK) disable iff (!RESET_N)
        bus_stop && stop_sel_q[1] && drive_mode_q[`POS_SERIAL_REF_STOP_DRIVE]
            && CLK_LOW[`IDX_SERIAL+1] |=> !OUT_DRIVE[`IDX_SERIAL+1];
    endproperty
    a_serial_stop_drive: assert property (p_serial_stop_drive)
        else $error("Stopped serial reference 1 driven in tri-state mode");

    property p_serial_pd_drive;
        @(posedge CLK) disable iff (!RESET_N)
        POWER_DOWN && drive_mode_q[`POS_SERIAL_REF_POWERDOWN_DRIVE] && CLK_LOW[`IDX_SERIAL+1]
            |=> !OUT_DRIVE[`IDX_SERIAL+1];
    endproperty
    a_serial_pd_drive: assert property (p_serial_pd_drive)
        else $error("Serial reference 1 driven in power-down tri-state mode");

    property p_proc_pd_drive;
        @(posedge CLK) disable iff (!RESET_N)
        POWER_DOWN && drive_mode_q[`POS_PROC_PAIR0_POWERDOWN_DRIVE] && CLK_LOW[`IDX_PROC]
            |=> !OUT_DRIVE[`IDX_PROC];
    endproperty
    a_proc_pd_drive: assert property (p_proc_pd_drive)
        else $error("Processor pair 0 driven in power-down tri-state mode");

    c_write_a: cover property (@(posedge CLK) disable iff (!RESET_N) REG_REQ.wr && hit_a);
    c_bus_stop: cover property (@(posedge CLK) disable iff (!RESET_N)
        bus_stop && stop_sel_q != 8'h00);
    c_test_ref: cover property (@(posedge CLK) disable iff (!RESET_N) TEST_REF_DIV);
endmodule

// ===== tb/smbus_host_model.sv
/*
 * Host controller model: issues byte and block accesses on the register port.
 * Assumes the protocol engine maps the command code offset onto REG_REQ.addr.
 */
`timescale 1ns/100ps
module smbus_host_model (
    input wire logic CLK,
    output clkctl_pkg::reg_req_t REG_REQ,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_RVALID
);
    initial REG_REQ = '0;

    // One request for one edge, then the strobes drop and address and data show the inverse of what they held
    task automatic access(input logic w, input logic [6:0] ofs, input logic [7:0] wd,
        output logic [7:0] rdat, output logic ok);
        logic [7:0] cmd;
        cmd = {1'b1, ofs};
        @(negedge CLK);
        REG_REQ = '{wr: w, rd: !w, addr: cmd[6:0], wdata: wd};
        @(negedge CLK);
        ok = w | REG_RVALID;
        rdat = REG_RDATA;
        REG_REQ = '{wr: 1'b0, rd: 1'b0, addr: ~cmd[6:0], wdata: ~wd};
    endtask

    // Block command 00: this task steps the offset up from the command's low bits
    task automatic block_read(output logic [7:0] blk [8], output logic ok);
        logic v;
        logic [7:0] cmd;
        ok = 1'b1;
        cmd = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            access(1'b0, cmd[6:0] + 7'(i), 8'h00, blk[i], v);
            ok = ok & v;
        end
    endtask
endmodule

// ===== tb/clk_output_control_tb.sv
/*
 * Self-checking bench of the clock output control bank.
 * Assumes the host model drives the register port; stops and CLK_LOW come from here.
 */
`timescale 1ns/100ps
`include "clkctl_defines.svh"
module clk_output_control_tb;
    typedef struct { logic [6:0] ofs; logic [7:0] wd; logic [7:0] exp; } row_t;
    logic CLK = 1'b0;
    logic RESET_N = 1'b0;
    clkctl_pkg::reg_req_t REG_REQ;
    logic [7:0] REG_RDATA;
    logic REG_RVALID;
    logic BUS_CLOCK_STOP_N = 1'b1;
    logic PROC_CLOCK_STOP_N = 1'b1;
    logic POWER_DOWN = 1'b0;
    logic SW_BUS_STOP = 1'b0;
    logic [`NUM_OUT-1:0] CLK_LOW = '1;
    logic [`NUM_OUT-1:0] OUT_RUN;
    logic [`NUM_OUT-1:0] OUT_DRIVE;
    logic SPREAD_ON;
    logic TEST_REF_DIV;
    logic [7:0] blk [8];
    logic ok;
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;
    wire logic [6:0] b2_run = {OUT_RUN[`IDX_FREE_PCI0], OUT_RUN[`IDX_VIDEO], OUT_RUN[`IDX_USB],
        OUT_RUN[`IDX_REF0], OUT_RUN[`IDX_REF1], OUT_RUN[`IDX_PROC+1], OUT_RUN[`IDX_PROC]};
    wire logic [7:0] ser_run = OUT_RUN[`IDX_SERIAL+7:`IDX_SERIAL];
    wire logic [7:0] ser_drv = OUT_DRIVE[`IDX_SERIAL+7:`IDX_SERIAL];
    row_t rows [8] = '{'{7'h02, 8'h55, 8'h55}, '{7'h03, 8'h00, 8'h00},
        '{7'h04, 8'hA5, 8'hA5}, '{7'h05, 8'hFF, 8'hFF}, '{7'h06, 8'h3C, 8'h3C},
        '{7'h07, 8'hFF, 8'hC0}, '{7'h08, 8'hFF, 8'h00}, '{7'h00, 8'h12, 8'h00}};
    logic [7:0] rst_exp [8] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h07, 8'h00, 8'h00};

    clk_output_control i_clk_output_control (.CLK(CLK), .RESET_N(RESET_N),
        .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
        .BUS_CLOCK_STOP_N(BUS_CLOCK_STOP_N), .PROC_CLOCK_STOP_N(PROC_CLOCK_STOP_N),
        .POWER_DOWN(POWER_DOWN), .SW_BUS_STOP(SW_BUS_STOP), .CLK_LOW(CLK_LOW),
        .OUT_RUN(OUT_RUN), .OUT_DRIVE(OUT_DRIVE), .SPREAD_ON(SPREAD_ON),
        .TEST_REF_DIV(TEST_REF_DIV));

    smbus_host_model i_smbus_host_model (.CLK(CLK), .REG_REQ(REG_REQ),
        .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID));

    initial
    begin
        forever #12.5 CLK = ~CLK;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge CLK)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic check(input logic [20:0] seen, input logic [20:0] exp, input string msg);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wr(input logic [6:0] ofs, input logic [7:0] d);
        logic [7:0] dummy;
        i_smbus_host_model.access(1'b1, ofs, d, dummy, ok);
    endtask

    task automatic rd_chk(input logic [6:0] ofs, input logic [7:0] exp);
        logic [7:0] d;
        i_smbus_host_model.access(1'b0, ofs, 8'h00, d, ok);
        check(21'(ok), 21'h1, "read valid");
        check(21'(d), 21'(exp), "read data");
        @(negedge CLK);
        check(21'(REG_RVALID), 21'h0, "valid pulse ends");
    endtask

    task automatic settle;
        repeat (3) @(negedge CLK);
    endtask

    task automatic do_reset;
        @(negedge CLK);
        RESET_N = 1'b0;
        repeat (12) @(negedge CLK);
        RESET_N = 1'b1;
    endtask

    initial
    begin
        repeat (12) @(negedge CLK);
        RESET_N = 1'b1;
        foreach (rows[i])
        begin
            wr(rows[i].ofs, rows[i].wd);
            rd_chk(rows[i].ofs, rows[i].exp);
        end
        // Second reset in mid-run
        @(negedge CLK);
        RESET_N = 1'b0;
        repeat (2) @(negedge CLK);
        check(OUT_RUN, 21'h0, "run in reset");
        check(OUT_DRIVE, '1, "drive in reset");
        check(21'(SPREAD_ON), 21'h1, "spread in reset");
        do_reset();
        i_smbus_host_model.block_read(blk, ok);
        check(21'(ok), 21'h1, "block valid");
        foreach (blk[i])
            check(21'(blk[i]), 21'(rst_exp[i]), "reset value");
        settle();
        check(21'(b2_run), 21'h7F, "enabled outputs");
        CLK_LOW = '0;
        wr(7'h02, 8'h00);
        settle();
        check(21'(SPREAD_ON), 21'h0, "spread off");
        check(21'(b2_run), 21'h7F, "gate waits for low");
        CLK_LOW = '1;
        settle();
        check(21'(b2_run), 21'h00, "disabled outputs");
        wr(7'h02, 8'hFE);
        settle();
        check(21'(b2_run), 21'h7F, "reenabled");
        check(21'(SPREAD_ON), 21'h0, "spread still off");
        wr(7'h02, 8'hFF);
        wr(7'h03, 8'h0D);
        settle();
        check(21'(OUT_RUN[`IDX_BUS+3:`IDX_BUS]), 21'h0, "bus clocks off");
        check(21'(OUT_RUN[`IDX_PROC+2]), 21'h0, "pair 2 off");
        rd_chk(7'h03, 8'h0D);
        wr(7'h03, 8'hFF);
        wr(7'h04, 8'h55);
        BUS_CLOCK_STOP_N = 1'b0;
        settle();
        check(21'(ser_run), 21'hAA, "serial stop select");
        check(21'(ser_drv), 21'hFF, "stopped but driven");
        wr(7'h06, 8'h80);
        settle();
        check(21'(ser_drv), 21'hAA, "stopped tri-state");
        BUS_CLOCK_STOP_N = 1'b1;
        wr(7'h06, 8'h00);
        wr(7'h04, 8'hAA);
        wr(7'h05, 8'h08);
        SW_BUS_STOP = 1'b1;
        settle();
        check(21'(ser_run), 21'h55, "software stop");
        check(21'(OUT_RUN[`IDX_FREE_PCI0]), 21'h0, "free clock stopped");
        wr(7'h05, 8'h00);
        settle();
        check(21'(OUT_RUN[`IDX_FREE_PCI0]), 21'h1, "free clock runs");
        SW_BUS_STOP = 1'b0;
        wr(7'h05, 8'h05);
        wr(7'h06, 8'h50);
        PROC_CLOCK_STOP_N = 1'b0;
        settle();
        check(21'(OUT_RUN[`IDX_PROC+2:`IDX_PROC]), 21'h2, "pair stop");
        check(21'(OUT_DRIVE[`IDX_PROC+2:`IDX_PROC]), 21'h2, "pair stop drive");
        PROC_CLOCK_STOP_N = 1'b1;
        wr(7'h05, 8'h40);
        wr(7'h06, 8'h0A);
        POWER_DOWN = 1'b1;
        settle();
        check(OUT_RUN, 21'h0, "power-down stops all");
        check(21'(ser_drv), 21'h01, "serial power-down drive");
        check(21'(OUT_DRIVE[`IDX_PROC+2:`IDX_PROC]), 21'h5, "pair power-down drive");
        check(21'(OUT_DRIVE[`IDX_VIDEO]), 21'h0, "dot tri-state");
        check(21'(OUT_DRIVE[`IDX_PANEL]), 21'h1, "panel driven");
        wr(7'h05, 8'h80);
        settle();
        check(21'(OUT_DRIVE[`IDX_VIDEO]), 21'h1, "dot driven");
        check(21'(OUT_DRIVE[`IDX_PANEL]), 21'h0, "panel tri-state");
        POWER_DOWN = 1'b0;
        wr(7'h07, 8'h80);
        settle();
        check(21'(TEST_REF_DIV), 21'h0, "select without entry");
        check(21'(OUT_DRIVE[`IDX_USB]), 21'h1, "normal drive");
        wr(7'h07, 8'h40);
        settle();
        check(OUT_DRIVE, 21'h0, "test tri-state");
        wr(7'h07, 8'hC0);
        settle();
        check(21'(TEST_REF_DIV), 21'h1, "divided reference");
        rd_chk(7'h07, 8'hC0);
        print_verdict();
    end
endmodule
